// *** pkg/pif_defines.vh ***
/*
 * register offsets, field positions and reset values of the identity and
 * interrupt-flag block. assumes an 8-bit register read port behind a
 * serial host interface decoded elsewhere.
 */
`ifndef PIF_DEFINES_VH
`define PIF_DEFINES_VH

`define PIF_OFF_CHIP_ID 8'h00
`define PIF_OFF_FLAGS_ONE 8'h01
`define PIF_OFF_FLAGS_TWO 8'h02
`define PIF_OFF_MASK_ONE 8'h03
`define PIF_OFF_MASK_TWO 8'h04

`define PIF_PART_MSB 7
`define PIF_PART_LSB 3
`define PIF_REV_MSB 2
`define PIF_REV_LSB 0

`define PIF_FLAG_WIDTH 6
`define PIF_FLAGS_RESET 6'h00
`define PIF_MASK_RESET 6'h00

// first flag register
`define PIF_BIT_LOW_PRG 5
`define PIF_BIT_MAINS 4
`define PIF_BIT_BUTTON 3
`define PIF_BIT_HOT 2
`define PIF_BIT_BATT_DONE 1
`define PIF_BIT_PRG_DONE 0

// second flag register
`define PIF_BIT_SW3_FAULT 5
`define PIF_BIT_SW2_FAULT 4
`define PIF_BIT_SW1_FAULT 3
`define PIF_BIT_SW3_LIMIT 2
`define PIF_BIT_SW2_LIMIT 1
`define PIF_BIT_SW1_LIMIT 0

`endif

// *** verilog/pif_flags.v ***
/*
 * identification register, two sticky interrupt-flag registers, their
 * mask registers and the active-low interrupt pin.
 * assumes the serial host front end presents one-cycle read and write
 * strobes with an 8-bit register offset, all synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pif_defines.vh"

// Summary of operation
// R1 - read-only identification: upper five bits part code, lower three revision; writes ignored.
// R2 - first flag register resets to zero; top two bits read zero.
// R3 - bit 5 sets when supply too low to program defaults.
// R4 - bit 4 sets on any mains-detect pin edge.
// R5 - bit 3 sets on any push-button pin edge.
// R6 - bit 2 reports thermal warning above threshold.
// R7 - bit 1 sets when backup battery comparators settle.
// R8 - bit 0 sets when default programming completes successfully.
// R9 - second flag register resets to zero; top two bits read zero.
// R10 - bit 5 sets on switch three overtemperature disable.
// R11 - bit 4 sets on switch two overtemperature or low input.
// R12 - bit 3 sets on switch one overtemperature disable.
// R13 - bits 2..0 set while switches three, two, one limit current.
// R14 - unmasked flags pull interrupt pin low; masking leaves monitoring intact.
// R15 - host reads these registers without any password.
// R16 - flags hold until read, then clear unless cause persists.
module pif_flags #(
    parameter [4:0] PART_CODE = 5'h01, // arbitrary value
    parameter [2:0] REV_CODE = 3'h1 // arbitrary value
) (
    input wire clk,
    input wire rst,
    input wire rd_stb,
    input wire wr_stb,
    input wire [7:0] reg_addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data_ff,
    input wire mains_detect_pin,
    input wire pushbutton_pin,
    input wire low_programming_supply,
    input wire thermal_over_warning,
    input wire backup_battery_settled,
    input wire defaults_programmed_ok,
    input wire [2:0] switch_fault,
    input wire [2:0] switch_limiting,
    output wire interrupt_request_pin_n
);

    localparam FLAG_W = `PIF_FLAG_WIDTH;
    localparam [5:0] FLAGS_RESET = `PIF_FLAGS_RESET;
    localparam [5:0] MASK_RESET = `PIF_MASK_RESET;

    // stored flag bits, mask bits and previous pin levels
    reg [FLAG_W-1:0] flags_one_ff;
    reg [FLAG_W-1:0] flags_two_ff;
    reg [FLAG_W-1:0] mask_one_ff;
    reg [FLAG_W-1:0] mask_two_ff;
    reg mains_prev_ff;
    reg button_prev_ff;
    reg edge_armed_ff;

    // next values
    reg [FLAG_W-1:0] nxt_mask_one;
    reg [FLAG_W-1:0] nxt_mask_two;
    reg [7:0] nxt_rd_data;
    wire [FLAG_W-1:0] nxt_flags_one;
    wire [FLAG_W-1:0] nxt_flags_two;

    // decoded host requests
    wire rd_one;
    wire rd_two;
    wire wr_mask_one;
    wire wr_mask_two;

    // per-bit set causes
    wire [FLAG_W-1:0] cause_one;
    wire [FLAG_W-1:0] cause_two;
    wire mains_edge;
    wire button_edge;

    // register images as the host reads them
    wire [4:0] part_code_field;
    wire [2:0] silicon_revision_field;
    wire [7:0] chip_identification;
    wire [7:0] interrupt_flags_one;
    wire [7:0] interrupt_flags_two;
    wire [7:0] mask_image_one;
    wire [7:0] mask_image_two;

    // named flag bits of the first register
    wire low_programming_supply_flag;
    wire mains_detect_change_flag;
    wire pushbutton_change_flag;
    wire thermal_warning_flag;
    wire backup_battery_sample_done_flag;
    wire defaults_programmed_flag;

    // named flag bits of the second register
    wire switch_three_fault_flag;
    wire switch_two_fault_flag;
    wire switch_one_fault_flag;
    wire switch_three_limiting_flag;
    wire switch_two_limiting_flag;
    wire switch_one_limiting_flag;

    // unmasked requests per register
    wire irq_one_pending;
    wire irq_two_pending;

    assign rd_one = rd_stb && (reg_addr == `PIF_OFF_FLAGS_ONE);
    assign rd_two = rd_stb && (reg_addr == `PIF_OFF_FLAGS_TWO);
    // id and flag registers are read-only; only masks take writes
    assign wr_mask_one = wr_stb && (reg_addr == `PIF_OFF_MASK_ONE); // see R1
    assign wr_mask_two = wr_stb && (reg_addr == `PIF_OFF_MASK_TWO);

    // edges only count once the previous levels were captured after reset
    assign mains_edge = edge_armed_ff && (mains_detect_pin != mains_prev_ff); // see R4
    assign button_edge = edge_armed_ff && (pushbutton_pin != button_prev_ff); // see R5

    assign cause_one[`PIF_BIT_LOW_PRG] = low_programming_supply; // see R3
    assign cause_one[`PIF_BIT_MAINS] = mains_edge; // see R4
    assign cause_one[`PIF_BIT_BUTTON] = button_edge; // see R5
    assign cause_one[`PIF_BIT_HOT] = thermal_over_warning; // see R6
    assign cause_one[`PIF_BIT_BATT_DONE] = backup_battery_settled; // see R7
    assign cause_one[`PIF_BIT_PRG_DONE] = defaults_programmed_ok; // see R8

    assign cause_two[`PIF_BIT_SW3_FAULT] = switch_fault[2]; // see R10
    assign cause_two[`PIF_BIT_SW2_FAULT] = switch_fault[1]; // see R11
    assign cause_two[`PIF_BIT_SW1_FAULT] = switch_fault[0]; // see R12
    assign cause_two[`PIF_BIT_SW3_LIMIT] = switch_limiting[2]; // see R13
    assign cause_two[`PIF_BIT_SW2_LIMIT] = switch_limiting[1]; // see R13
    assign cause_two[`PIF_BIT_SW1_LIMIT] = switch_limiting[0]; // see R13

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi = gi + 1) begin : g_flag_bit
            // read clears, but a cause present in the same cycle wins
            assign nxt_flags_one[gi] = (flags_one_ff[gi] & ~rd_one) | cause_one[gi]; // see R16
            assign nxt_flags_two[gi] = (flags_two_ff[gi] & ~rd_two) | cause_two[gi]; // see R16

            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    flags_one_ff[gi] <= FLAGS_RESET[gi]; // see R2
                    flags_two_ff[gi] <= FLAGS_RESET[gi]; // see R9
                end else begin
                    flags_one_ff[gi] <= nxt_flags_one[gi];
                    flags_two_ff[gi] <= nxt_flags_two[gi];
                end
            end
        end
    endgenerate

    assign low_programming_supply_flag = flags_one_ff[`PIF_BIT_LOW_PRG];
    assign mains_detect_change_flag = flags_one_ff[`PIF_BIT_MAINS];
    assign pushbutton_change_flag = flags_one_ff[`PIF_BIT_BUTTON];
    assign thermal_warning_flag = flags_one_ff[`PIF_BIT_HOT];
    assign backup_battery_sample_done_flag = flags_one_ff[`PIF_BIT_BATT_DONE];
    assign defaults_programmed_flag = flags_one_ff[`PIF_BIT_PRG_DONE];

    assign switch_three_fault_flag = flags_two_ff[`PIF_BIT_SW3_FAULT];
    assign switch_two_fault_flag = flags_two_ff[`PIF_BIT_SW2_FAULT];
    assign switch_one_fault_flag = flags_two_ff[`PIF_BIT_SW1_FAULT];
    assign switch_three_limiting_flag = flags_two_ff[`PIF_BIT_SW3_LIMIT];
    assign switch_two_limiting_flag = flags_two_ff[`PIF_BIT_SW2_LIMIT];
    assign switch_one_limiting_flag = flags_two_ff[`PIF_BIT_SW1_LIMIT];

    assign part_code_field = PART_CODE; // see R1
    assign silicon_revision_field = REV_CODE; // see R1
    assign chip_identification = {part_code_field, silicon_revision_field}; // see R1

    // reserved top bits are wired to zero, never stored
    assign interrupt_flags_one = {2'h0,
        low_programming_supply_flag,
        mains_detect_change_flag,
        pushbutton_change_flag,
        thermal_warning_flag,
        backup_battery_sample_done_flag,
        defaults_programmed_flag}; // see R2
    assign interrupt_flags_two = {2'h0,
        switch_three_fault_flag,
        switch_two_fault_flag,
        switch_one_fault_flag,
        switch_three_limiting_flag,
        switch_two_limiting_flag,
        switch_one_limiting_flag}; // see R9
    assign mask_image_one = {2'h0, mask_one_ff};
    assign mask_image_two = {2'h0, mask_two_ff};

    always @* begin
        nxt_mask_one = mask_one_ff;
        nxt_mask_two = mask_two_ff;
        if (wr_mask_one) begin
            nxt_mask_one = wr_data[5:0];
        end
        if (wr_mask_two) begin
            nxt_mask_two = wr_data[5:0];
        end
    end

    // no password gate on reads
    always @* begin
        case (reg_addr)
            `PIF_OFF_CHIP_ID: nxt_rd_data = chip_identification; // see R1
            `PIF_OFF_FLAGS_ONE: nxt_rd_data = interrupt_flags_one; // see R2
            `PIF_OFF_FLAGS_TWO: nxt_rd_data = interrupt_flags_two; // see R9
            `PIF_OFF_MASK_ONE: nxt_rd_data = mask_image_one;
            `PIF_OFF_MASK_TWO: nxt_rd_data = mask_image_two;
            default: nxt_rd_data = 8'h00;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_one_ff <= MASK_RESET;
            mask_two_ff <= MASK_RESET;
        end else begin
            mask_one_ff <= nxt_mask_one;
            mask_two_ff <= nxt_mask_two;
        end
    end

    // pins are synchronous, so one stored level per pin is enough
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mains_prev_ff <= 1'b0;
            button_prev_ff <= 1'b0;
            edge_armed_ff <= 1'b0;
        end else begin
            mains_prev_ff <= mains_detect_pin;
            button_prev_ff <= pushbutton_pin;
            edge_armed_ff <= 1'b1;
        end
    end

    // read data holds between reads so a slow front end can shift it out
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= 8'h00;
        end else begin
            if (rd_stb) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    // mask gates only the pin, never the flag bits themselves
    assign irq_one_pending = |(flags_one_ff & ~mask_one_ff); // see R14
    assign irq_two_pending = |(flags_two_ff & ~mask_two_ff); // see R14
    assign interrupt_request_pin_n = ~(irq_one_pending | irq_two_pending); // see R14

endmodule // pif_flags
`default_nettype wire

// *** bench/pif_flags_asserts.sv ***
/* checker on pif_flags ports; expects default part and revision codes */
`timescale 1ns/1ps
`default_nettype none
module pif_flags_asserts (
    input wire clk, input wire rst, input wire rd_stb,
    input wire [7:0] reg_addr, input wire [7:0] rd_data_ff,
    input wire mains_detect_pin, input wire pushbutton_pin, input wire low_programming_supply,
    input wire thermal_over_warning, input wire backup_battery_settled,
    input wire defaults_programmed_ok, input wire [2:0] switch_fault, input wire [2:0] switch_limiting
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence rd1; rd_stb && reg_addr == 8'h01; endsequence
    sequence rd2; rd_stb && reg_addr == 8'h02; endsequence
    a_id_value: assert property (rd_stb && reg_addr == 8'h00 |=> rd_data_ff == 8'h09) else $error("id");
    a_mains_edge: assert property ($changed(mains_detect_pin) && !$past(rst) ##1 rd1 |=> rd_data_ff[4]) else $error("mains");
    a_button_edge: assert property ($changed(pushbutton_pin) && !$past(rst) ##1 rd1 |=> rd_data_ff[3]) else $error("button");
    a_one_levels: assert property (rd1 ##0 !$past(rst) |=> ($past({low_programming_supply, 2'b00,
        thermal_over_warning, backup_battery_settled, defaults_programmed_ok}, 2) & ~rd_data_ff[5:0]) == 6'h00) else $error("lvl1");
    a_two_levels: assert property (rd2 ##0 !$past(rst) |=> ($past({switch_fault, switch_limiting}, 2)
        & ~rd_data_ff[5:0]) == 6'h00) else $error("lvl2");
    a_clear_read: assert property (rd2 ##1 rd2 |=> rd_data_ff[5:0] == $past({switch_fault, switch_limiting}, 2)) else $error("clr");
    a_reserved_zero: assert property (rd1 or rd2 |=> rd_data_ff[7:6] == 2'b00) else $error("rsvd");
    a_read_holds: assert property (!rd_stb |=> $stable(rd_data_ff)) else $error("hold");
endmodule // pif_flags_asserts
bind pif_flags pif_flags_asserts pif_flags_asserts_inst (.clk, .rst, .rd_stb, .reg_addr, .rd_data_ff,
    .mains_detect_pin, .pushbutton_pin, .low_programming_supply, .thermal_over_warning,
    .backup_battery_settled, .defaults_programmed_ok, .switch_fault, .switch_limiting);
`default_nettype wire

// *** bench/pif_host.sv ***
/* host model issuing one-cycle register requests; caller sits just after an edge */
`timescale 1ns/1ps
`default_nettype none
module pif_host (
    input wire logic clk, output logic rd_stb, output logic wr_stb,
    output logic [7:0] reg_addr, output logic [7:0] wr_data
);
    // reads go straight out, no password first
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        rd_stb = !w; wr_stb = w; reg_addr = a; wr_data = d;
        @(posedge clk); #1;
    endtask
    task idle; rd_stb = 1'b0; wr_stb = 1'b0; endtask
endmodule // pif_host
`default_nettype wire

// *** bench/pif_flags_test.sv ***
/* bench for pif_flags: host model requests, random causes, mirror model */
`timescale 1ns/1ps
`default_nettype none
module pif_flags_test;
    `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
    logic clk = 0, rst = 1, qm, qb, rd_stb, wr_stb;
    logic [7:0] reg_addr, wr_data, er;
    logic [11:0] cz = 12'h000;
    logic [5:0] e1, e2, m1, m2;
    logic [31:0] s = 32'h0001_4d24;
    wire [7:0] rd_data_ff;
    wire interrupt_request_pin_n;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    always #5 clk = ~clk;
    pif_host pif_host_inst (.clk, .rd_stb, .wr_stb, .reg_addr, .wr_data);
    pif_flags pif_flags_inst (.clk, .rst, .rd_stb, .wr_stb, .reg_addr, .wr_data, .rd_data_ff,
        .mains_detect_pin(cz[11]), .pushbutton_pin(cz[10]), .low_programming_supply(cz[9]),
        .thermal_over_warning(cz[8]), .backup_battery_settled(cz[7]), .defaults_programmed_ok(cz[6]),
        .switch_fault(cz[5:3]), .switch_limiting(cz[2:0]), .interrupt_request_pin_n);
    function logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13); v = v ^ (v >> 17); return v ^ (v << 5);
    endfunction
    function logic [7:0] exp_rd(input logic [7:0] a);
        return a == 8'h00 ? 8'h09 : a == 8'h01 ? {2'b00, e1} : a == 8'h02 ? {2'b00, e2}
            : a == 8'h03 ? {2'b00, m1} : a == 8'h04 ? {2'b00, m2} : 8'h00;
    endfunction
    // set beats read-clear, so causes are or-ed in after the clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            e1 <= 6'h00; e2 <= 6'h00; m1 <= 6'h00; m2 <= 6'h00; qm <= cz[11]; qb <= cz[10];
        end else begin
            qm <= cz[11]; qb <= cz[10];
            e1 <= (rd_stb && reg_addr == 8'h01 ? 6'h00 : e1) | {cz[9], cz[11] ^ qm, cz[10] ^ qb, cz[8:6]};
            e2 <= (rd_stb && reg_addr == 8'h02 ? 6'h00 : e2) | cz[5:0];
            if (wr_stb && reg_addr == 8'h03) m1 <= wr_data[5:0];
            if (wr_stb && reg_addr == 8'h04) m2 <= wr_data[5:0];
            if (rd_stb) er <= exp_rd(reg_addr);
        end
    end
    task step(input logic w, input logic [7:0] a, input logic [7:0] d);
        pif_host_inst.xfer(w, a, d);
        `CHK("pin_n", ~|((e1 & ~m1) | (e2 & ~m2)), interrupt_request_pin_n)
        if (!w) `CHK("rd_data", er, rd_data_ff)
    endtask
    task tally_and_finish;
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 4000) begin n_errors++; tally_and_finish(); end
    end
    initial begin
        pif_host_inst.idle();
        repeat (2) @(posedge clk);
        #1 rst = 0;
        // reset values of offsets 0 to 7, the unmapped ones 5 to 7 included
        for (int i = 0; i < 8; i++) step(1'b0, 8'(i), 8'h00);
        repeat (2500) begin
            s = xs(s);
            cz = s[11:0] & s[27:16];
            step(s[31], {5'h00, s[30:28]}, s[23:16]);
        end
        pif_host_inst.idle();
        // second reset in mid-run with the causes held still
        #1 rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        `CHK("rd_rst", 8'h00, rd_data_ff)
        `CHK("pin_rst", 1'b1, interrupt_request_pin_n)
        for (int i = 0; i < 5; i++) step(1'b0, 8'(i), 8'h00);
        pif_host_inst.idle();
        tally_and_finish();
    end
endmodule // pif_flags_test
`default_nettype wire
